/* core_alu.v */
// combinational 8-bit alu with flag outputs
`timescale 1ns/1ps
`default_nettype none
`include "core_defines.vh"

module core_alu (
  // operands
  input  wire [3:0] op,
  input  wire [7:0] src_a,
  input  wire [7:0] src_b,
  input  wire       cy_in,
  input  wire       ac_in,
  // results
  output reg  [7:0] res,
  output reg  [7:0] res_hi,
  output reg        cy_out,
  output reg        ac_out,
  output reg        ov_out
);

  reg [8:0]  sum;
  reg [4:0]  low;
  reg [15:0] prod;
  reg [8:0]  adj;

  // operation select, carry and half carry kept unless the op defines them, overflow cleared
  always @* begin
    res    = 8'h00;
    res_hi = src_b;
    cy_out = cy_in;
    ac_out = ac_in;
    ov_out = 1'b0;
    sum    = 9'h000;
    low    = 5'h00;
    prod   = 16'h0000;
    adj    = 9'h000;
    case (op)
      `ALU_ADD, `ALU_ADDC: begin
        sum    = {1'b0, src_a} + {1'b0, src_b} + {8'h00, (op == `ALU_ADDC) & cy_in};
        low    = {1'b0, src_a[3:0]} + {1'b0, src_b[3:0]} + {4'h0, (op == `ALU_ADDC) & cy_in};
        res    = sum[7:0];
        cy_out = sum[8];
        ac_out = low[4];
        ov_out = (src_a[7] == src_b[7]) && (sum[7] != src_a[7]);
      end
      `ALU_SUBB, `ALU_CMP: begin
        sum    = {1'b0, src_a} - {1'b0, src_b} - {8'h00, (op == `ALU_SUBB) & cy_in};
        low    = {1'b0, src_a[3:0]} - {1'b0, src_b[3:0]} - {4'h0, (op == `ALU_SUBB) & cy_in};
        res    = (op == `ALU_CMP) ? src_a : sum[7:0];
        cy_out = sum[8];
        ac_out = (op == `ALU_CMP) ? ac_in : low[4];
        ov_out = (src_a[7] != src_b[7]) && (sum[7] != src_a[7]);
      end
      `ALU_INC: res = src_a + 8'h01;
      `ALU_DEC: res = src_a - 8'h01;
      `ALU_MUL: begin
        prod   = src_a * src_b;
        res    = prod[7:0];
        res_hi = prod[15:8];
        cy_out = 1'b0;
        ov_out = |prod[15:8];
      end
      `ALU_DIV: begin
        cy_out = 1'b0;
        ov_out = (src_b == 8'h00);
        res    = (src_b == 8'h00) ? 8'hFF : src_a / src_b;
        res_hi = (src_b == 8'h00) ? src_a : src_a % src_b;
      end
      `ALU_DA: begin
        adj = {1'b0, src_a};
        if (adj[3:0] > 4'h9 || ac_in)
          adj = adj + 9'h006;
        if (adj[8:4] > 5'h09 || cy_in)
          adj = adj + 9'h060;
        res    = adj[7:0];
        cy_out = cy_in | adj[8];
      end
      `ALU_AND:  res = src_a & src_b;
      `ALU_OR:   res = src_a | src_b;
      `ALU_XOR:  res = src_a ^ src_b;
      `ALU_CPL:  res = ~src_a;
      `ALU_RL:   res = {src_a[6:0], src_a[7]};
      `ALU_RR:   res = {src_a[0], src_a[7:1]};
      `ALU_SWAP: res = {src_a[3:0], src_a[7:4]};
      default:   res = src_a;
    endcase
  end

endmodule
`default_nettype wire

/* core_defines.vh */
// timing constants, register offsets, field positions and reset values of the cpu core
`ifndef CORE_DEFINES_VH
`define CORE_DEFINES_VH

// machine cycle timing
`define STATES_PER_CYCLE    3'd6
`define LAST_STATE          3'd5
`define ALE_FIRST_STATE     3'd0
`define ALE_SECOND_STATE    3'd3
`define OPC_STATE           3'd0
`define OPND_STATE          3'd3
`define EXEC_STATE          3'd5

// apb byte addresses
`define ADDR_PSW            12'h0D0
`define ADDR_SP             12'h081
`define ADDR_ACC            12'h0E0
`define ADDR_B              12'h0F0
`define ADDR_PC             12'h084
`define ADDR_IR             12'h088
`define ADDR_STAT           12'h08C

// status word fields
`define PSW_CY              7
`define PSW_AC              6
`define PSW_F0              5
`define PSW_RS1             4
`define PSW_RS0             3
`define PSW_OV              2
`define PSW_F1              1
`define PSW_P               0

// reset values
`define SP_RESET            8'h07
`define PSW_RESET           8'h00
`define PC_RESET            16'h0000

// alu operation codes
`define ALU_ADD             4'h0
`define ALU_ADDC            4'h1
`define ALU_SUBB            4'h2
`define ALU_INC             4'h3
`define ALU_DEC             4'h4
`define ALU_MUL             4'h5
`define ALU_DIV             4'h6
`define ALU_DA              4'h7
`define ALU_AND             4'h8
`define ALU_OR              4'h9
`define ALU_XOR             4'hA
`define ALU_CPL             4'hB
`define ALU_RL              4'hC
`define ALU_RR              4'hD
`define ALU_SWAP            4'hE
`define ALU_CMP             4'hF

`endif

/* cpu_core.v */
// cpu core: state timing, fetch sequencing, alu, bit processor, status word and apb registers
//
// Contract
// - a machine cycle is six states, two oscillator periods each, no prescaler; the core spends two sys_clk periods per state
// - each state splits into phase 1 and phase 2, twelve phases per cycle
// - alu work happens in phase 1, register transfers in phase 2
// - instructions are one to three bytes, taking one, two or four cycles; the core fetches at most two bytes
// - address latch strobe high S1P2-S2P1 and S4P2-S5P1 each cycle
// - opcode is latched into the instruction register at S1P2
// - second byte of a two-byte one-cycle instruction is read in S4
// - one-byte instructions still fetch in S4, discard it, keep counter
// - a one-cycle instruction completes at the end of S6P2
// - alu takes 8-bit operands and supports the full arithmetic and logic set
// - bit processor sets, clears, complements, branches, and ands/ors into carry
// - 16-bit counter holds next address; branches redirect execution
// - two bank-select bits map registers to 00-07, 08-0F, 10-17, 18-1F
// - parity flag follows the accumulator after every instruction, even parity
// - stack pointer increments before push/call, decrements after pop/return
// - stack pointer resets to 07 and is readable and writable by software
// - b register is multiply/divide operand and result, else scratch
// - arithmetic updates carry and overflow; half carry for decimal ops
// - five addressing modes: direct, immediate, register, indirect, base plus index
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "core_defines.vh"

module cpu_core (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // program memory
  output reg  [15:0] code_addr,
  input  wire [7:0]  code_data,
  output reg         addr_latch_strobe,
  // decoded instruction control
  input  wire        exec_valid,
  input  wire        instr_two_byte,
  input  wire [2:0]  instr_cycles,
  input  wire [3:0]  alu_op,
  input  wire [1:0]  src_b_mode,
  input  wire [2:0]  dst_sel,
  input  wire [2:0]  bit_op,
  input  wire [2:0]  bit_pos,
  input  wire [7:0]  bit_byte,
  input  wire [1:0]  stack_op,
  input  wire        branch_take_ext,
  input  wire [15:0] branch_target,
  input  wire [7:0]  src_data,
  input  wire [2:0]  reg_num,
  // decoded results
  output reg  [7:0]  opcode,
  output reg  [7:0]  operand,
  output reg  [7:0]  reg_addr,
  output reg  [15:0] data_ptr_index,
  output reg         phase_two,
  output reg  [2:0]  state_num,
  output reg         cycle_done
);

  // ---------------------------------------------------------------
  // timing state counter
  // ---------------------------------------------------------------
  reg        phase_r;
  reg [2:0]  state_r;
  reg [2:0]  mcyc_r;
  reg [7:0]  ir_r;
  reg [7:0]  opnd_r;
  reg [15:0] pc_r;
  reg [7:0]  acc_r;
  reg [7:0]  b_r;
  reg [7:0]  psw_r;
  reg [7:0]  sp_r;
  reg        discard_r;

  wire end_of_cycle = (state_r == `LAST_STATE) && phase_r;
  wire last_mcyc    = (mcyc_r + 3'd1 >= instr_cycles) || (instr_cycles == 3'd0);

  // phase toggles every clock; states step on phase 2
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
      state_r <= 3'd0;
      mcyc_r  <= 3'd0;
    end else begin
      phase_r <= ~phase_r;
      if (phase_r) begin
        if (state_r == `LAST_STATE) begin
          state_r <= 3'd0;
          if (exec_valid && !last_mcyc)
            mcyc_r <= mcyc_r + 3'd1;
          else
            mcyc_r <= 3'd0;
        end else begin
          state_r <= state_r + 3'd1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // address latch strobe and fetch addressing
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_latch_strobe <= 1'b0;
    end else begin
      // high from S1P2 to S2P1 and S4P2 to S5P1
      // decided one clock ahead, while the core sits in S1 or S4
      addr_latch_strobe <= (state_r == `ALE_FIRST_STATE) ||
                           (state_r == `ALE_SECOND_STATE);
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_two  <= 1'b0;
      state_num  <= 3'd0;
      cycle_done <= 1'b0;
      code_addr  <= `PC_RESET;
    end else begin
      phase_two  <= ~phase_r;
      state_num  <= phase_r ? ((state_r == `LAST_STATE) ? 3'd0 : state_r + 3'd1) : state_r;
      cycle_done <= end_of_cycle && last_mcyc;
      code_addr  <= pc_r;
    end
  end

  // ---------------------------------------------------------------
  // alu instance, operand B select
  // ---------------------------------------------------------------
  reg  [7:0] alu_b;
  wire [7:0] alu_res;
  wire [7:0] alu_res_hi;
  wire       alu_cy;
  wire       alu_ac;
  wire       alu_ov;

  // immediate, direct/register data, or b register
  always @* begin
    case (src_b_mode)
      2'd0:    alu_b = opnd_r;
      2'd1:    alu_b = src_data;
      2'd2:    alu_b = b_r;
      default: alu_b = 8'h00;
    endcase
  end

  core_alu u_alu (
    .op     (alu_op),
    .src_a  (acc_r),
    .src_b  (alu_b),
    .cy_in  (psw_r[`PSW_CY]),
    .ac_in  (psw_r[`PSW_AC]),
    .res    (alu_res),
    .res_hi (alu_res_hi),
    .cy_out (alu_cy),
    .ac_out (alu_ac),
    .ov_out (alu_ov)
  );

  // latched alu result from phase 1, written back in phase 2
  reg [7:0] res_r;
  reg [7:0] res_hi_r;
  reg       cy_r;
  reg       ac_r;
  reg       ov_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res_r    <= 8'h00;
      res_hi_r <= 8'h00;
      cy_r     <= 1'b0;
      ac_r     <= 1'b0;
      ov_r     <= 1'b0;
    end else if (!phase_r) begin
      res_r    <= alu_res;
      res_hi_r <= alu_res_hi;
      cy_r     <= alu_cy;
      ac_r     <= alu_ac;
      ov_r     <= alu_ov;
    end
  end

  // ---------------------------------------------------------------
  // bit processor
  // ---------------------------------------------------------------
  reg  bit_val;
  reg  carry_nxt;
  reg  [7:0] bit_byte_nxt;
  reg  bit_branch;

  // ops: 0 set,1 clr,2 cpl,3 anl,4 anl not,5 orl,6 orl not,7 mov to carry
  always @* begin
    bit_val      = bit_byte[bit_pos];
    carry_nxt    = psw_r[`PSW_CY];
    bit_byte_nxt = bit_byte;
    bit_branch   = bit_val;
    case (bit_op)
      3'd0:    bit_byte_nxt[bit_pos] = 1'b1;
      3'd1:    bit_byte_nxt[bit_pos] = 1'b0;
      3'd2:    bit_byte_nxt[bit_pos] = ~bit_val;
      3'd3:    carry_nxt = carry_nxt & bit_val;
      3'd4:    carry_nxt = carry_nxt & ~bit_val;
      3'd5:    carry_nxt = carry_nxt | bit_val;
      3'd6:    carry_nxt = carry_nxt | ~bit_val;
      default: carry_nxt = bit_val;
    endcase
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire apb_wr = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // ---------------------------------------------------------------
  // fetch, program counter and instruction registers
  // ---------------------------------------------------------------
  wire pc_wr = apb_wr && is_addr(paddr, `ADDR_PC);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_r      <= `PC_RESET;
      ir_r      <= 8'h00;
      opnd_r    <= 8'h00;
      discard_r <= 1'b0;
    end else if (pc_wr) begin
      pc_r <= pwdata[15:0];
    end else if (phase_r && mcyc_r == 3'd0) begin
      if (state_r == `OPC_STATE) begin
        ir_r <= code_data;
        pc_r <= pc_r + 16'h0001;
      end else if (state_r == `OPND_STATE) begin
        if (instr_two_byte) begin
          opnd_r    <= code_data;
          pc_r      <= pc_r + 16'h0001;
          discard_r <= 1'b0;
        end else begin
          discard_r <= 1'b1;
        end
      end else if (end_of_cycle && exec_valid && (branch_take_ext || (bit_op == 3'd7 && bit_branch))) begin
        pc_r <= branch_target;
      end
    end else if (end_of_cycle && exec_valid && branch_take_ext) begin
      pc_r <= branch_target;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opcode  <= 8'h00;
      operand <= 8'h00;
    end else begin
      opcode  <= ir_r;
      operand <= discard_r ? 8'h00 : opnd_r;
    end
  end

  // ---------------------------------------------------------------
  // accumulator, b, status word and stack pointer write-back
  // ---------------------------------------------------------------
  wire wb = end_of_cycle && exec_valid;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_r <= 8'h00;
      b_r   <= 8'h00;
      psw_r <= `PSW_RESET;
      sp_r  <= `SP_RESET;
    end else begin
      if (apb_wr && is_addr(paddr, `ADDR_ACC))
        acc_r <= pwdata[7:0];
      else if (wb && dst_sel == 3'd1)
        acc_r <= res_r;
      else if (wb && dst_sel == 3'd2)
        acc_r <= res_r;
      if (apb_wr && is_addr(paddr, `ADDR_B))
        b_r <= pwdata[7:0];
      else if (wb && dst_sel == 3'd2)
        b_r <= res_hi_r;
      else if (wb && dst_sel == 3'd3)
        b_r <= res_r;
      if (apb_wr && is_addr(paddr, `ADDR_PSW))
        psw_r[7:1] <= pwdata[7:1];
      else if (wb && (dst_sel == 3'd1 || dst_sel == 3'd2)) begin
        psw_r[`PSW_CY] <= cy_r;
        psw_r[`PSW_AC] <= ac_r;
        psw_r[`PSW_OV] <= ov_r;
      end else if (wb && dst_sel == 3'd4)
        psw_r[`PSW_CY] <= carry_nxt;
      psw_r[`PSW_P] <= ^acc_r;
      if (apb_wr && is_addr(paddr, `ADDR_SP))
        sp_r <= pwdata[7:0];
      else if (wb && stack_op == 2'd1)
        sp_r <= sp_r + 8'h01;
      else if (wb && stack_op == 2'd2)
        sp_r <= sp_r - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // register bank and indexed address
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_addr       <= 8'h00;
      data_ptr_index <= 16'h0000;
    end else begin
      reg_addr       <= {3'b000, psw_r[`PSW_RS1], psw_r[`PSW_RS0], reg_num};
      data_ptr_index <= branch_target + {8'h00, acc_r};
    end
  end

  // ---------------------------------------------------------------
  // apb read mux
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ADDR_PSW:  prdata <= {24'h000000, psw_r};
        `ADDR_SP:   prdata <= {24'h000000, sp_r};
        `ADDR_ACC:  prdata <= {24'h000000, acc_r};
        `ADDR_B:    prdata <= {24'h000000, b_r};
        `ADDR_PC:   prdata <= {16'h0000, pc_r};
        `ADDR_IR:   prdata <= {16'h0000, opnd_r, ir_r};
        `ADDR_STAT: prdata <= {16'h0000, bit_byte_nxt, discard_r, mcyc_r, phase_r, state_r};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* cpu_core_assertions.sv */
// concurrent checks on the cpu core timing, fetch and apb ports
`timescale 1ns/1ps
`default_nettype none

module cpu_core_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb answer
  input wire logic        psel,
  input wire logic        pready,
  input wire logic        pslverr,
  // fetch side
  input wire logic [15:0] code_addr,
  input wire logic        addr_latch_strobe,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand,
  input wire logic [7:0]  reg_addr,
  // timing
  input wire logic        phase_two,
  input wire logic [2:0]  state_num,
  input wire logic        cycle_done
);
  // ------------------------------------------------
  // cycle length counter
  // ------------------------------------------------
  logic [3:0] gap_r;
  logic       seen_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // clocks since the last state 1 phase 1
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_r  <= 4'h0;
      seen_r <= 1'b0;
    end else if (state_num == 3'd0 && !phase_two) begin
      gap_r  <= 4'h1;
      seen_r <= 1'b1;
    end else begin
      gap_r  <= gap_r + 4'h1;
    end
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  chk_cycle_len: assert property (seen_r && state_num == 3'd0 && !phase_two &&
                                  $past(state_num) == 3'd5 |-> gap_r == 4'hC)
    else $error("machine cycle is not twelve clocks");
  chk_phase_alt: assert property (phase_two |=> !phase_two)
    else $error("phase two not followed by phase one");
  chk_state_step: assert property (phase_two && state_num != 3'd5 |=> state_num == $past(state_num) + 3'd1)
    else $error("state did not advance after phase two");
  chk_state_wrap: assert property (phase_two && state_num == 3'd5 |=> state_num == 3'd0 && !phase_two)
    else $error("state six did not wrap to state one");
  chk_strobe_win: assert property (addr_latch_strobe ==
                                   ((phase_two && (state_num == 3'd0 || state_num == 3'd3)) ||
                                    (!phase_two && (state_num == 3'd1 || state_num == 3'd4))))
    else $error("address latch strobe outside its windows");
  chk_opcode_hold: assert property (state_num inside {3'd1, 3'd2, 3'd3, 3'd4} |-> ##2 $stable(opcode))
    else $error("opcode changed mid cycle");
  chk_operand_hold: assert property (state_num inside {3'd0, 3'd1} |=> $stable(operand))
    else $error("operand changed outside state four");
  chk_done_pulse: assert property (cycle_done |-> $past(state_num) == 3'd5 && $past(phase_two)
                                   ##1 !cycle_done)
    else $error("cycle end pulse misplaced");
  chk_fetch_hold: assert property (state_num == 3'd2 |=> $stable(code_addr))
    else $error("fetch address moved in state three");
  chk_apb_answer: assert property (psel |-> pready && !pslverr)
    else $error("register access not answered cleanly");
  chk_bank_top: assert property (reg_addr[7:5] == 3'h0)
    else $error("register address above bank area");
endmodule

bind cpu_core cpu_core_checker u_cpu_core_checker (.sys_clk(sys_clk), .rst(rst), .psel(psel), .pready(pready),
  .pslverr(pslverr), .code_addr(code_addr), .addr_latch_strobe(addr_latch_strobe), .opcode(opcode),
  .operand(operand), .reg_addr(reg_addr), .phase_two(phase_two), .state_num(state_num), .cycle_done(cycle_done));

`default_nettype wire

/* prog_mem_model.sv */
// program memory model serving opcode bytes from a fixed pattern
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model (
  // fetch address
  input  wire logic [15:0] code_addr,
  // fetched byte
  output logic      [7:0]  code_data
);
  // every address within a 256-byte page holds a different byte so a wrong fetch shows up
  assign code_data = (code_addr[7:0] * 8'h05 + 8'h3C) ^ code_addr[15:8];
endmodule

`default_nettype wire

/* testbench.sv */
// self-checking testbench for the cpu core
`timescale 1ns/1ps
`default_nettype none
`include "core_defines.vh"

module testbench;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] code_addr, branch_target, data_ptr_index;
  logic [7:0]  code_data, bit_byte, src_data, opcode, operand, reg_addr;
  logic        addr_latch_strobe, exec_valid, instr_two_byte, branch_take_ext, phase_two, cycle_done;
  logic [2:0]  instr_cycles, dst_sel, bit_op, bit_pos, reg_num, state_num;
  logic [3:0]  alu_op;
  logic [1:0]  src_b_mode, stack_op;
  int          failures, check_count;

  cpu_core u_cpu_core (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .code_addr(code_addr), .code_data(code_data), .addr_latch_strobe(addr_latch_strobe),
    .exec_valid(exec_valid), .instr_two_byte(instr_two_byte), .instr_cycles(instr_cycles), .alu_op(alu_op),
    .src_b_mode(src_b_mode), .dst_sel(dst_sel), .bit_op(bit_op), .bit_pos(bit_pos), .bit_byte(bit_byte),
    .stack_op(stack_op), .branch_take_ext(branch_take_ext), .branch_target(branch_target),
    .src_data(src_data), .reg_num(reg_num), .opcode(opcode), .operand(operand), .reg_addr(reg_addr),
    .data_ptr_index(data_ptr_index), .phase_two(phase_two), .state_num(state_num), .cycle_done(cycle_done));

  prog_mem_model u_prog_mem_model (.code_addr(code_addr), .code_data(code_data));

  // free running oscillator clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  function automatic logic [7:0] pm(input logic [15:0] a);
    return (a[7:0] * 8'h05 + 8'h3C) ^ a[15:8];
  endfunction

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    failures++;
    $display("Error at %0t: timeout waiting for %s", $time, what);
    summarize();
  endtask

  // one apb transfer, read data left in rd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang("pready");
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_at(input logic [2:0] s, input logic p);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while ((state_num !== s || phase_two !== p) && n < 40);
    if (n >= 40) hang("state");
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cycle_done !== 1'b1 && n < 40);
    if (n >= 40) hang("cycle end");
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset;
    apb(1'b0, `ADDR_SP, 32'h0);
    chk(rd, 32'h07, "stack pointer reset");
    apb(1'b0, 12'h0FC, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask

  task automatic t_regs;
    logic [7:0] v [5] = '{8'h00, 8'h01, 8'h07, 8'h81, 8'hFE};
    apb(1'b1, `ADDR_B, 32'hA5);
    apb(1'b0, `ADDR_B, 32'h0);
    chk(rd, 32'hA5, "b scratch");
    apb(1'b1, `ADDR_SP, 32'h3C);
    apb(1'b0, `ADDR_SP, 32'h0);
    chk(rd, 32'h3C, "stack pointer write");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `ADDR_ACC, {24'h0, v[i]});
      apb(1'b1, `ADDR_PSW, 32'hFF);
      apb(1'b0, `ADDR_PSW, 32'h0);
      chk(rd, {24'h0, 7'h7F, ^v[i]}, "status bits and parity");
    end
  endtask

  task automatic t_bank;
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, `ADDR_PSW, {27'h0, b[1:0], 3'h0});
      apb(1'b0, `ADDR_PSW, 32'h0);
      chk({24'h0, reg_addr}, {27'h0, b[1:0], 3'h6}, "bank address");
    end
  endtask

  task automatic t_timing;
    wait_at(3'd0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      chk({28'h0, state_num, phase_two}, {28'h0, 3'(i % 12 / 2), 1'(i % 2)}, "state and phase");
      chk({31'h0, addr_latch_strobe}, {31'h0, 1'(i % 6 == 1 || i % 6 == 2)}, "strobe");
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic t_fetch(input logic two);
    logic [15:0] pc0;
    @(posedge sys_clk);
    exec_valid     <= 1'b1;
    instr_two_byte <= two;
    wait_at(3'd0, 1'b0);
    wait_at(3'd0, 1'b0);
    pc0 = code_addr;
    wait_at(3'd5, 1'b1);
    chk({24'h0, opcode}, {24'h0, pm(pc0)}, "opcode");
    chk({24'h0, operand}, two ? {24'h0, pm(pc0 + 16'h1)} : 32'h0, "operand");
    chk({16'h0, code_addr}, {16'h0, pc0 + 16'h1 + {15'h0, two}}, "next address");
    wait_done;
    chk({28'h0, state_num, phase_two}, 32'h0, "completion point");
  endtask

  task automatic t_stack;
    apb(1'b1, `ADDR_SP, 32'h07);
    wait_done;
    stack_op <= 2'd1;
    wait_done;
    stack_op <= 2'd0;
    apb(1'b0, `ADDR_SP, 32'h0);
    chk(rd, 32'h08, "push");
    wait_done;
    stack_op <= 2'd2;
    wait_done;
    stack_op <= 2'd0;
    apb(1'b0, `ADDR_SP, 32'h0);
    chk(rd, 32'h07, "pop");
  endtask

  task automatic t_mul;
    apb(1'b1, `ADDR_ACC, 32'h12);
    apb(1'b1, `ADDR_B, 32'h34);
    wait_done;
    alu_op     <= `ALU_MUL;
    src_b_mode <= 2'd2;
    dst_sel    <= 3'd2;
    wait_done;
    dst_sel    <= 3'd0;
    src_b_mode <= 2'd0;
    apb(1'b0, `ADDR_ACC, 32'h0);
    chk(rd, 32'hA8, "product low");
    apb(1'b0, `ADDR_B, 32'h0);
    chk(rd, 32'h03, "product high");
  endtask

  task automatic t_branch;
    wait_done;
    branch_target   <= 16'h1230;
    branch_take_ext <= 1'b1;
    wait_done;
    branch_take_ext <= 1'b0;
    wait_at(3'd5, 1'b1);
    chk({24'h0, opcode}, {24'h0, pm(16'h1230)}, "branch target fetch");
  endtask

  // bit moved into carry, then a two machine cycle instruction
  task automatic t_bitmc;
    int n;
    wait_done;
    bit_byte <= 8'h04;
    bit_pos  <= 3'd2;
    bit_op   <= 3'd7;
    dst_sel  <= 3'd4;
    wait_done;
    {bit_op, dst_sel} <= 6'h00;
    apb(1'b0, `ADDR_PSW, 32'h0);
    chk({31'h0, rd[7]}, 32'h1, "bit moved to carry");
    wait_done;
    instr_cycles <= 3'd2;
    wait_done;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cycle_done !== 1'b1 && n < 40);
    instr_cycles <= 3'd1;
    chk(n, 24, "two cycle instruction length");
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {exec_valid, instr_two_byte, alu_op, src_b_mode, dst_sel, bit_op, bit_pos} = '0;
    {bit_byte, stack_op, branch_take_ext, branch_target, src_data} = '0;
    instr_cycles = 3'd1;
    reg_num = 3'd6;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_bank();
    t_timing();
    t_fetch(1'b0);
    t_fetch(1'b1);
    t_stack();
    t_mul();
    t_branch();
    t_bitmc();
    summarize();
  end
endmodule

`default_nettype wire
